// ===== core/pamux_defs.svh
/*
  offsets, field positions, masks and reset values of the port A pin
  function selector; included by the top module and the bench
*/
`ifndef PAMUX_DEFS_SVH
`define PAMUX_DEFS_SVH

// register byte offsets
`define PAMUX_LOW_OFF 8'h00
`define PAMUX_HIGH_OFF 8'h04
`define PAMUX_UNLOCK_OFF 8'h08
`define PAMUX_LEVEL_OFF 8'h0C

// reset values, all fields general I/O
`define PAMUX_LOW_RESET 32'h0000_0000
`define PAMUX_HIGH_RESET 32'h0000_0000
`define PAMUX_UNLOCK_RESET 1'b0

// writable bits, everything else reads zero
`define PAMUX_LOW_MASK 32'h0300_FFFF
`define PAMUX_HIGH_MASK 32'h0F00_00FF

// field lsb positions, low selector
`define PAMUX_P0_LSB 0
`define PAMUX_P1_LSB 2
`define PAMUX_P2_LSB 4
`define PAMUX_P3_LSB 6
`define PAMUX_P4_LSB 8
`define PAMUX_P5_LSB 10
`define PAMUX_P6_LSB 12
`define PAMUX_P7_LSB 14
`define PAMUX_P12_LSB 24
// field lsb positions, high selector
`define PAMUX_P16_LSB 0
`define PAMUX_P17_LSB 2
`define PAMUX_P18_LSB 4
`define PAMUX_P19_LSB 6
`define PAMUX_P28_LSB 24
`define PAMUX_P29_LSB 26

// axi responses
`define PAMUX_RESP_OKAY 2'b00
`define PAMUX_RESP_SLVERR 2'b10

`endif

// ===== core/pamux_pkg.sv
/*
  types of the port A pin function selector; assumes nothing beyond
  the defines header
*/
package pamux_pkg;

  // selector codes
  typedef enum logic [1:0] {
    PAMUX_GPIO = 2'b00,
    PAMUX_ALT1 = 2'b01,
    PAMUX_ALT2 = 2'b10,
    PAMUX_ALT3 = 2'b11
  } pamux_code_type;

  // signals the peripherals offer to the pins
  typedef struct packed {
    logic pwm_unit1_out_a;
    logic pwm_unit1_out_b;
    logic pwm_unit2_out_a;
    logic pwm_unit2_out_b;
    logic pwm_unit3_out_a;
    logic pwm_unit3_out_b;
    logic pwm_unit4_out_a;
    logic pwm_unit4_out_b;
    logic pwm_sync_output;
    logic serial_a_transmit;
    logic comparator_one_output;
    logic comparator_two_output;
    logic external_clock_output;
    logic spi_port_a_mosi;
    logic spi_port_a_mosi_oe;
    logic spi_port_a_miso;
    logic spi_port_a_miso_oe;
    logic spi_port_a_clock;
    logic spi_port_a_clock_oe;
    logic spi_port_a_select;
    logic spi_port_a_select_oe;
    logic capture_unit_one;
    logic capture_unit_one_oe;
    logic i2c_a_data_line_low;
    logic i2c_a_clock_line_low;
  } pamux_periph_out_type;

  // pin levels handed to the peripherals
  typedef struct packed {
    logic trip_zone_one;
    logic trip_zone_two;
    logic trip_zone_three;
    logic serial_a_receive;
    logic pwm_sync_input;
    logic spi_port_a_mosi;
    logic spi_port_a_miso;
    logic spi_port_a_clock;
    logic spi_port_a_select;
    logic capture_unit_one;
    logic i2c_a_data_line;
    logic i2c_a_clock_line;
  } pamux_periph_in_type;

endpackage

// ===== core/pamux_top.sv
/*
  port A pin function selector: two protected selector registers on
  an axi4-lite slave pick general I/O or a peripheral for 15 pins.
  assumes pins arrive asynchronously and peripherals share aclk.
*/
// Register access over AXI4-Lite and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "pamux_defs.svh"

// Behaviour
// - all selector fields reset to general I/O
// - selector writes ignored while unlock is clear
// - pin 0 general I/O or pwm1 A
// - pin 1 general I/O, pwm1 B, comparator 1
// - pin 2 general I/O or pwm2 A
// - pin 3 general I/O, pwm2 B, comparator 2
// - pin 4 general I/O or pwm3 A
// - pin 5 general I/O, pwm3 B, capture
// - pin 6 pwm4 A, sync in, sync out
// - pin 7 pwm4 B or serial receive
// - pin 12 trip zone 1 or serial transmit
// - pin 16 spi mosi or trip zone 2
// - pin 17 spi miso or trip zone 3
// - pin 18 spi clock, transmit, clock out
// - pin 19 spi select, receive, capture
// - pin 28 receive, i2c data, trip 2
// - pin 29 transmit, i2c clock, trip 3
module pamux_top import pamux_pkg::*; #(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic [14:0] pin_in,
  output logic [14:0] pin_out,
  output logic [14:0] pin_oe,
  input wire logic [14:0] gpio_out,
  input wire logic [14:0] gpio_oe,
  output logic [14:0] gpio_in,
  input wire pamux_periph_out_type periph_out,
  output pamux_periph_in_type periph_in
);

  // pin index order on every pin vector
  localparam int P0 = 0;
  localparam int P1 = 1;
  localparam int P2 = 2;
  localparam int P3 = 3;
  localparam int P4 = 4;
  localparam int P5 = 5;
  localparam int P6 = 6;
  localparam int P7 = 7;
  localparam int P12 = 8;
  localparam int P16 = 9;
  localparam int P17 = 10;
  localparam int P18 = 11;
  localparam int P19 = 12;
  localparam int P28 = 13;
  localparam int P29 = 14;

  logic [31:0] low_sel;
  logic [31:0] high_sel;
  logic unlock;
  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic [14:0] sync1;
  logic [14:0] sync2;
  logic [14:0] sync3;
  logic [14:0] level;
  pamux_code_type code [15];
  logic [14:0][1:0] next_drive;
  pamux_periph_in_type next_periph_in;

  // two-bit field extraction
  function automatic pamux_code_type field(input logic [31:0] r, input int lsb);
    field = pamux_code_type'(r[lsb +: 2]);
  endfunction

  // byte-strobe merge limited to writable bits
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s, input logic [31:0] m);
    logic [31:0] be;
    be = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    merge = (old & ~(be & m)) | (d & be & m);
  endfunction

  // address match against a byte offset
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
    hit = (a == ADDR_W'(off));
  endfunction

  // write channel capture, either order
  assign awready = !aw_held;
  assign wready = !w_held;
  assign wr_fire = aw_held && w_held && !bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (awvalid && awready) begin
      aw_held <= 1'b1;
      aw_addr <= awaddr;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (wvalid && wready) begin
      w_held <= 1'b1;
      w_data <= wdata;
      w_strb <= wstrb;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= `PAMUX_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid <= 1'b1;
      if (hit(aw_addr, `PAMUX_LOW_OFF) || hit(aw_addr, `PAMUX_HIGH_OFF) ||
          hit(aw_addr, `PAMUX_UNLOCK_OFF) || hit(aw_addr, `PAMUX_LEVEL_OFF)) begin
        bresp <= `PAMUX_RESP_OKAY;
      end else begin
        bresp <= `PAMUX_RESP_SLVERR;
      end
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // selector registers, protected by the unlock bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_sel <= `PAMUX_LOW_RESET;
      high_sel <= `PAMUX_HIGH_RESET;
    end else if (wr_fire && unlock) begin
      if (hit(aw_addr, `PAMUX_LOW_OFF)) begin
        low_sel <= merge(low_sel, w_data, w_strb, `PAMUX_LOW_MASK);
      end
      if (hit(aw_addr, `PAMUX_HIGH_OFF)) begin
        high_sel <= merge(high_sel, w_data, w_strb, `PAMUX_HIGH_MASK);
      end
    end
  end

  // unlock bit, always writable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      unlock <= `PAMUX_UNLOCK_RESET;
    end else if (wr_fire && hit(aw_addr, `PAMUX_UNLOCK_OFF) && w_strb[0]) begin
      unlock <= w_data[0];
    end
  end

  // read channel, one cycle answer
  assign arready = !rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= `PAMUX_RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp <= `PAMUX_RESP_OKAY;
      if (hit(araddr, `PAMUX_LOW_OFF)) begin
        rdata <= low_sel;
      end else if (hit(araddr, `PAMUX_HIGH_OFF)) begin
        rdata <= high_sel;
      end else if (hit(araddr, `PAMUX_UNLOCK_OFF)) begin
        rdata <= {31'h0000_0000, unlock};
      end else if (hit(araddr, `PAMUX_LEVEL_OFF)) begin
        rdata <= {17'h0_0000, level};
      end else begin
        rdata <= '0;
        rresp <= `PAMUX_RESP_SLVERR;
      end
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // pin synchroniser, level taken once stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      level <= '0;
    end else begin
      sync1 <= pin_in;
      sync2 <= sync1;
      sync3 <= sync2;
      level <= (sync2 & sync3) | (level & (sync2 ^ sync3));
    end
  end

  // field decode per pin
  assign code[P0] = field(low_sel, `PAMUX_P0_LSB);
  assign code[P1] = field(low_sel, `PAMUX_P1_LSB);
  assign code[P2] = field(low_sel, `PAMUX_P2_LSB);
  assign code[P3] = field(low_sel, `PAMUX_P3_LSB);
  assign code[P4] = field(low_sel, `PAMUX_P4_LSB);
  assign code[P5] = field(low_sel, `PAMUX_P5_LSB);
  assign code[P6] = field(low_sel, `PAMUX_P6_LSB);
  assign code[P7] = field(low_sel, `PAMUX_P7_LSB);
  assign code[P12] = field(low_sel, `PAMUX_P12_LSB);
  assign code[P16] = field(high_sel, `PAMUX_P16_LSB);
  assign code[P17] = field(high_sel, `PAMUX_P17_LSB);
  assign code[P18] = field(high_sel, `PAMUX_P18_LSB);
  assign code[P19] = field(high_sel, `PAMUX_P19_LSB);
  assign code[P28] = field(high_sel, `PAMUX_P28_LSB);
  assign code[P29] = field(high_sel, `PAMUX_P29_LSB);

  // pin drive {oe, out}; reserved codes leave the pin undriven
  always_comb begin
    for (int i = 0; i < 15; i++) begin
      next_drive[i] = (code[i] == PAMUX_GPIO) ? {gpio_oe[i], gpio_out[i]} : 2'b00;
    end
    if (code[P0] == PAMUX_ALT1) next_drive[P0] = {1'b1, periph_out.pwm_unit1_out_a};
    if (code[P1] == PAMUX_ALT1) next_drive[P1] = {1'b1, periph_out.pwm_unit1_out_b};
    if (code[P1] == PAMUX_ALT3) next_drive[P1] = {1'b1, periph_out.comparator_one_output};
    if (code[P2] == PAMUX_ALT1) next_drive[P2] = {1'b1, periph_out.pwm_unit2_out_a};
    if (code[P3] == PAMUX_ALT1) next_drive[P3] = {1'b1, periph_out.pwm_unit2_out_b};
    if (code[P3] == PAMUX_ALT3) next_drive[P3] = {1'b1, periph_out.comparator_two_output};
    if (code[P4] == PAMUX_ALT1) next_drive[P4] = {1'b1, periph_out.pwm_unit3_out_a};
    if (code[P5] == PAMUX_ALT1) next_drive[P5] = {1'b1, periph_out.pwm_unit3_out_b};
    if (code[P5] == PAMUX_ALT3) begin
      next_drive[P5] = {periph_out.capture_unit_one_oe, periph_out.capture_unit_one};
    end
    if (code[P6] == PAMUX_ALT1) next_drive[P6] = {1'b1, periph_out.pwm_unit4_out_a};
    if (code[P6] == PAMUX_ALT3) next_drive[P6] = {1'b1, periph_out.pwm_sync_output};
    if (code[P7] == PAMUX_ALT1) next_drive[P7] = {1'b1, periph_out.pwm_unit4_out_b};
    if (code[P12] == PAMUX_ALT2) next_drive[P12] = {1'b1, periph_out.serial_a_transmit};
    if (code[P16] == PAMUX_ALT1) begin
      next_drive[P16] = {periph_out.spi_port_a_mosi_oe, periph_out.spi_port_a_mosi};
    end
    if (code[P17] == PAMUX_ALT1) begin
      next_drive[P17] = {periph_out.spi_port_a_miso_oe, periph_out.spi_port_a_miso};
    end
    if (code[P18] == PAMUX_ALT1) begin
      next_drive[P18] = {periph_out.spi_port_a_clock_oe, periph_out.spi_port_a_clock};
    end
    if (code[P18] == PAMUX_ALT2) next_drive[P18] = {1'b1, periph_out.serial_a_transmit};
    if (code[P18] == PAMUX_ALT3) next_drive[P18] = {1'b1, periph_out.external_clock_output};
    if (code[P19] == PAMUX_ALT1) begin
      next_drive[P19] = {periph_out.spi_port_a_select_oe, periph_out.spi_port_a_select};
    end
    if (code[P19] == PAMUX_ALT3) begin
      next_drive[P19] = {periph_out.capture_unit_one_oe, periph_out.capture_unit_one};
    end
    if (code[P28] == PAMUX_ALT2) next_drive[P28] = {periph_out.i2c_a_data_line_low, 1'b0};
    if (code[P29] == PAMUX_ALT1) next_drive[P29] = {1'b1, periph_out.serial_a_transmit};
    if (code[P29] == PAMUX_ALT2) next_drive[P29] = {periph_out.i2c_a_clock_line_low, 1'b0};
  end

  // peripheral inputs, idle high, lowest pin wins on a double choice
  always_comb begin
    next_periph_in = '1;
    if (code[P12] == PAMUX_ALT1) next_periph_in.trip_zone_one = level[P12];
    if (code[P28] == PAMUX_ALT3) next_periph_in.trip_zone_two = level[P28];
    if (code[P16] == PAMUX_ALT3) next_periph_in.trip_zone_two = level[P16];
    if (code[P29] == PAMUX_ALT3) next_periph_in.trip_zone_three = level[P29];
    if (code[P17] == PAMUX_ALT3) next_periph_in.trip_zone_three = level[P17];
    if (code[P28] == PAMUX_ALT1) next_periph_in.serial_a_receive = level[P28];
    if (code[P19] == PAMUX_ALT2) next_periph_in.serial_a_receive = level[P19];
    if (code[P7] == PAMUX_ALT2) next_periph_in.serial_a_receive = level[P7];
    if (code[P6] == PAMUX_ALT2) next_periph_in.pwm_sync_input = level[P6];
    if (code[P16] == PAMUX_ALT1) next_periph_in.spi_port_a_mosi = level[P16];
    if (code[P17] == PAMUX_ALT1) next_periph_in.spi_port_a_miso = level[P17];
    if (code[P18] == PAMUX_ALT1) next_periph_in.spi_port_a_clock = level[P18];
    if (code[P19] == PAMUX_ALT1) next_periph_in.spi_port_a_select = level[P19];
    if (code[P19] == PAMUX_ALT3) next_periph_in.capture_unit_one = level[P19];
    if (code[P5] == PAMUX_ALT3) next_periph_in.capture_unit_one = level[P5];
    if (code[P28] == PAMUX_ALT2) next_periph_in.i2c_a_data_line = level[P28];
    if (code[P29] == PAMUX_ALT2) next_periph_in.i2c_a_clock_line = level[P29];
  end

  // registered pin and peripheral side
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_out <= '0;
      pin_oe <= '0;
      gpio_in <= '0;
      periph_in <= '1;
    end else begin
      for (int i = 0; i < 15; i++) begin
        pin_oe[i] <= next_drive[i][1];
        pin_out[i] <= next_drive[i][0];
      end
      gpio_in <= level;
      periph_in <= next_periph_in;
    end
  end

  a_reset_gpio_default: assert property (@(posedge aclk)
    !aresetn |=> (low_sel == 32'h0 && high_sel == 32'h0 && pin_oe == 15'h0))
    else $error("selectors not general I/O after reset");

  a_locked_write_ignored: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_fire && !unlock) |=> ($stable(low_sel) && $stable(high_sel)))
    else $error("selector changed while locked");

  a_reserved_bits_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    ((low_sel & ~32'h0300_FFFF) == 32'h0) && ((high_sel & ~32'h0F00_00FF) == 32'h0))
    else $error("reserved selector bits set");

  a_pin0_pwm_route: assert property (@(posedge aclk) disable iff (!aresetn)
    (low_sel[1:0] == 2'b01) |=> (pin_oe[0] && pin_out[0] == $past(periph_out.pwm_unit1_out_a)))
    else $error("pin 0 not driven by pwm1 A");

  a_pin1_comp_route: assert property (@(posedge aclk) disable iff (!aresetn)
    (low_sel[3:2] == 2'b11) |=>
      (pin_oe[1] && pin_out[1] == $past(periph_out.comparator_one_output)))
    else $error("pin 1 not driven by comparator 1");

  a_pin6_sync_in: assert property (@(posedge aclk) disable iff (!aresetn)
    (low_sel[13:12] == 2'b10) |=>
      (!pin_oe[6] && periph_in.pwm_sync_input == $past(level[6])))
    else $error("pin 6 sync input misrouted");

  a_pin12_trip_zone: assert property (@(posedge aclk) disable iff (!aresetn)
    (low_sel[25:24] == 2'b01) |=> (!pin_oe[8] && periph_in.trip_zone_one == $past(level[8])))
    else $error("pin 12 trip zone misrouted");

  a_pin28_i2c_drain: assert property (@(posedge aclk) disable iff (!aresetn)
    (high_sel[25:24] == 2'b10) |=>
      (pin_out[13] == 1'b0 && pin_oe[13] == $past(periph_out.i2c_a_data_line_low)))
    else $error("pin 28 not open-drain i2c data");

  a_pin18_clock_out: assert property (@(posedge aclk) disable iff (!aresetn)
    (high_sel[5:4] == 2'b11) |=>
      (pin_oe[11] && pin_out[11] == $past(periph_out.external_clock_output)))
    else $error("pin 18 not driven by clock output");

  a_gpio_path_owner: assert property (@(posedge aclk) disable iff (!aresetn)
    (low_sel[15:14] != 2'b00) |=> (pin_oe[7] == 1'b0 || $past(code[P7]) == PAMUX_ALT1))
    else $error("general I/O still drives pin 7");

endmodule // pamux_top

// ===== test/pamux_partner.sv
/*
  pad model beside the port A selector: resolves each pad level
  from the selector drive and a board driver that always drives
*/
`timescale 1ns/1ps
module pamux_partner (
  input wire logic [14:0] pin_out,
  input wire logic [14:0] pin_oe,
  input wire logic [14:0] ext_level,
  output logic [14:0] pin_in
);
  // selector drive wins, else the board level shows
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule // pamux_partner

// ===== test/pamux_tb.sv
/*
  self-checking bench of the port A selector with a behavioural model;
  assumes the defines header and package are compiled first
*/
`timescale 1ns/1ps
`include "pamux_defs.svh"
module pamux_tb import pamux_pkg::*;;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'h0;
  logic [1:0] bresp, rresp;
  logic [14:0] pin_in, pin_out, pin_oe, gpio_in, go = 15'h0, ge = 15'h0, ext = 15'h0;
  pamux_periph_out_type po = '0;
  pamux_periph_in_type pi;
  logic [31:0] low = 32'h0, high = 32'h0, seed = 32'h0000_000E;
  logic unl = 1'b0;
  int num_errors = 0;
  int checks_done = 0;

  // 50 MHz clock
  always #10 aclk = ~aclk;

  pamux_top #(.ADDR_W(8)) pamux_top_inst (.aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
    .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .gpio_out(go), .gpio_oe(ge), .gpio_in(gpio_in),
    .periph_out(po), .periph_in(pi));
  pamux_partner pamux_partner_inst (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext),
    .pin_in(pin_in));

  // verdict and end of run
  task automatic tally_and_finish();
    if (num_errors == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask

  // xorshift source of stimulus
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // pin index times four plus code, reserved selections
  function automatic bit res(int k);
    return k inside {2, 3, 6, 10, 11, 14, 18, 19, 22, 31, 35, 38, 42};
  endfunction

  function automatic int lsb(int i);
    return i < 8 ? 2 * i : i == 8 ? 24 : i < 13 ? 2 * (i - 9) : 24 + 2 * (i - 13);
  endfunction

  function automatic int code(int i);
    return int'(((i < 9 ? low : high) >> lsb(i)) & 32'h3);
  endfunction

  // expected pad drive of one pin
  function automatic void drv(input int i, input int c, output logic oe, output logic o);
    oe = 1'b1;
    o = 1'b0;
    case (i * 4 + c)
      1: o = po.pwm_unit1_out_a;
      5: o = po.pwm_unit1_out_b;
      7: o = po.comparator_one_output;
      9: o = po.pwm_unit2_out_a;
      13: o = po.pwm_unit2_out_b;
      15: o = po.comparator_two_output;
      17: o = po.pwm_unit3_out_a;
      21: o = po.pwm_unit3_out_b;
      25: o = po.pwm_unit4_out_a;
      27: o = po.pwm_sync_output;
      29: o = po.pwm_unit4_out_b;
      34, 46, 57: o = po.serial_a_transmit;
      47: o = po.external_clock_output;
      23, 51: {oe, o} = {po.capture_unit_one_oe, po.capture_unit_one};
      37: {oe, o} = {po.spi_port_a_mosi_oe, po.spi_port_a_mosi};
      41: {oe, o} = {po.spi_port_a_miso_oe, po.spi_port_a_miso};
      45: {oe, o} = {po.spi_port_a_clock_oe, po.spi_port_a_clock};
      49: {oe, o} = {po.spi_port_a_select_oe, po.spi_port_a_select};
      54: oe = po.i2c_a_data_line_low;
      58: oe = po.i2c_a_clock_line_low;
      default: {oe, o} = (c == 0) ? {ge[i], go[i]} : 2'b00;
    endcase
  endfunction

  function automatic logic [14:0] lvl();
    logic oe, o;
    logic [14:0] l;
    for (int i = 0; i < 15; i++) begin
      drv(i, code(i), oe, o);
      l[i] = oe ? o : ext[i];
    end
    return l;
  endfunction

  // expected peripheral inputs, lowest pin wins
  function automatic pamux_periph_in_type inm(input logic [14:0] l);
    pamux_periph_in_type p;
    p = '1;
    for (int i = 14; i >= 0; i--) begin
      case (i * 4 + code(i))
        26: p.pwm_sync_input = l[i];
        30, 50, 53: p.serial_a_receive = l[i];
        23, 51: p.capture_unit_one = l[i];
        33: p.trip_zone_one = l[i];
        39, 55: p.trip_zone_two = l[i];
        43, 59: p.trip_zone_three = l[i];
        37: p.spi_port_a_mosi = l[i];
        41: p.spi_port_a_miso = l[i];
        45: p.spi_port_a_clock = l[i];
        49: p.spi_port_a_select = l[i];
        54: p.i2c_a_data_line = l[i];
        58: p.i2c_a_clock_line = l[i];
        default: ;
      endcase
    end
    return p;
  endfunction

  // one axi4-lite write, each channel released when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bit ap, wp, bp, ta, tw, tb;
    logic [1:0] r;
    int n;
    ap = 1;
    wp = 1;
    bp = 1;
    n = 0;
    @(posedge aclk);
    {awvalid, wvalid, bready} <= 3'b111;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    while ((ap || wp || bp) && n < 100) begin
      @(negedge aclk);
      ta = ap && awready;
      tw = wp && wready;
      tb = bp && !ap && !wp && bvalid;
      r = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
      ap = ap && !ta;
      wp = wp && !tw;
      bp = bp && !tb;
      n++;
    end
    if (n >= 100) num_errors++;
    chk("bresp", 32'(r), 32'(er));
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    bit ap, bp, ta, tb;
    int n;
    ap = 1;
    bp = 1;
    n = 0;
    @(posedge aclk);
    {arvalid, rready} <= 2'b11;
    araddr <= a;
    while ((ap || bp) && n < 100) begin
      @(negedge aclk);
      ta = ap && arready;
      tb = bp && !ap && rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (tb) rready <= 1'b0;
      ap = ap && !ta;
      bp = bp && !tb;
      n++;
    end
    if (n >= 100) num_errors++;
  endtask

  // register write with model update
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    axi_wr(a, d, (a[7:4] == 4'h0 && a[1:0] == 2'b00) ? `PAMUX_RESP_OKAY : `PAMUX_RESP_SLVERR);
    if (a == `PAMUX_UNLOCK_OFF) unl = d[0];
    else if (unl && a == `PAMUX_LOW_OFF) low = d & `PAMUX_LOW_MASK;
    else if (unl && a == `PAMUX_HIGH_OFF) high = d & `PAMUX_HIGH_MASK;
  endtask

  task automatic reg_rd(input logic [7:0] a);
    logic [31:0] d, e;
    logic [1:0] r, er;
    er = `PAMUX_RESP_OKAY;
    case (a)
      `PAMUX_LOW_OFF: e = low;
      `PAMUX_HIGH_OFF: e = high;
      `PAMUX_UNLOCK_OFF: e = {31'h0, unl};
      `PAMUX_LEVEL_OFF: e = {17'h0, lvl()};
      default: {e, er} = {32'h0, `PAMUX_RESP_SLVERR};
    endcase
    axi_rd(a, d, r);
    chk("rdata", d, e);
    chk("rresp", 32'(r), 32'(er));
  endtask

  // new peripheral, gpio and board levels, then compare the pads
  task automatic stim();
    logic oe, o;
    logic [14:0] eo, ev;
    @(posedge aclk);
    po <= pamux_periph_out_type'(25'(rnd()));
    go <= 15'(rnd());
    ge <= 15'(rnd());
    ext <= 15'(rnd());
    repeat (10) @(posedge aclk);
    @(negedge aclk);
    for (int i = 0; i < 15; i++) begin
      drv(i, code(i), oe, o);
      eo[i] = oe;
      ev[i] = o;
    end
    chk("pin_oe", 32'(pin_oe), 32'(eo));
    chk("pin_out", 32'(pin_out & eo), 32'(ev & eo));
    chk("gpio_in", 32'(gpio_in), 32'(lvl()));
    chk("periph_in", 32'(pi), 32'(inm(lvl())));
  endtask

  // k below 4 puts code k on every pin, else random codes; reserved picks become general I/O
  task automatic cfg(input int k);
    logic [31:0] nl, nh;
    int c;
    nl = rnd() & ~`PAMUX_LOW_MASK;
    nh = rnd() & ~`PAMUX_HIGH_MASK;
    for (int i = 0; i < 15; i++) begin
      c = k < 4 ? k : int'(rnd() & 32'h3);
      if (res(i * 4 + c)) c = 0;
      if (i < 9) nl = nl | (32'(c) << lsb(i));
      else nh = nh | (32'(c) << lsb(i));
    end
    reg_wr(`PAMUX_LOW_OFF, nl);
    reg_wr(`PAMUX_HIGH_OFF, nh);
    reg_rd(`PAMUX_LOW_OFF);
    reg_rd(`PAMUX_HIGH_OFF);
    reg_rd(`PAMUX_LEVEL_OFF);
    repeat (3) stim();
  endtask

  // main sequence
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    stim();
    reg_rd(`PAMUX_LOW_OFF);
    reg_rd(`PAMUX_HIGH_OFF);
    reg_rd(`PAMUX_UNLOCK_OFF);
    reg_wr(`PAMUX_LOW_OFF, 32'h0000_5555);
    reg_wr(`PAMUX_HIGH_OFF, 32'h0500_0055);
    reg_rd(`PAMUX_LOW_OFF);
    reg_rd(`PAMUX_HIGH_OFF);
    stim();
    reg_wr(`PAMUX_UNLOCK_OFF, 32'h0000_0001);
    reg_rd(`PAMUX_UNLOCK_OFF);
    reg_wr(`PAMUX_LEVEL_OFF, 32'hFFFF_FFFF);
    reg_rd(`PAMUX_LEVEL_OFF);
    reg_wr(8'h10, 32'h0000_0001);
    reg_rd(8'h10);
    reg_rd(8'h3C);
    for (int k = 0; k < 10; k++) cfg(k);
    reg_wr(`PAMUX_UNLOCK_OFF, 32'h0000_0000);
    reg_wr(`PAMUX_LOW_OFF, 32'h0000_0000);
    reg_rd(`PAMUX_LOW_OFF);
    stim();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    {low, high, unl} = '0;
    reg_rd(`PAMUX_LOW_OFF);
    reg_rd(`PAMUX_HIGH_OFF);
    stim();
    tally_and_finish();
  end

  // watchdog, well past the expected run length
  initial begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    tally_and_finish();
  end
endmodule // pamux_tb
